/* verilog/ccr_command_config.sv */
// Command behaviour configuration register pair with erase blank check.
`timescale 1ns/1ns

// Operation
// - Both copies are reached only by generic register read and write.
// - Power-on, hardware or software reset copies boot bits into live.
// - Boot bits may flip once from factory state, never back.
// - Bits 7,6,2,1 reserved; factory boot value is all zero.
// - Bit 5 enables blank check for erase commands.
// - Blank check: failed previous erase means erase unconditionally.
// - Previous erase good: read sector, erase on first programmed zero.
// - No programmed zero found: skip erase and complete the command.
// - Blank check covers parameter, sector and bulk erase.
// - Blank check off: every erase but a rejected parameter erase starts unconditionally.
// - Bit 4 selects page buffer wrap at 512 (one) or 256 (zero).
// - 256 wrap folds load addresses past 255 back to zero.
// - Bit 3 set removes 4 KB parameter sectors; clear keeps hybrid map.
// - Parameter sectors overlay top or bottom 32 KB, or vanish.
// - Live sector-map bit is read-only; changes only via boot bit.
// - Bit 0 gates the single-byte legacy software reset.
// - The enable-then-reset pair always resets the device.
module ccr_command_config (
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              hw_reset_i,
  input  wire ccr_pkg::ccr_cmd_t cmd_i,
  output logic [7:0]             rd_data_o,
  output logic                   rd_valid_o,
  output logic                   sw_reset_o,
  output ccr_pkg::ccr_cfg_t      cfg_o,
  input  wire logic              erase_req_i,
  input  wire logic [1:0]        erase_kind_i,
  input  wire logic              sector_erase_ok_i,
  output logic                   blank_rd_o,
  input  wire logic              blank_word_valid_i,
  input  wire logic [31:0]       blank_word_i,
  input  wire logic              blank_last_i,
  output logic                   erase_start_o,
  output logic                   erase_skip_o,
  output logic                   erase_reject_o,
  input  wire logic [8:0]        load_addr_i,
  output logic [8:0]             buf_addr_o
);

  ccr_pkg::ccr_state_t q;
  ccr_pkg::ccr_state_t d;

  logic cmd_read;
  logic cmd_write;
  logic cmd_legacy;
  logic cmd_pair_rst;
  logic reload;

  // Live copy as loaded from the boot copy at any reset.
  function automatic logic [7:0] boot_to_live(input logic [7:0] boot);
    boot_to_live = boot & ~ccr_pkg::CCR_RESERVED_MASK;
  endfunction

  function automatic logic hits(input ccr_pkg::ccr_cmd_t c,
                                input logic [7:0]        op);
    hits = c.valid && (c.op == op);
  endfunction

  assign cmd_read     = hits(cmd_i, ccr_pkg::CCR_OP_REG_READ);
  assign cmd_write    = hits(cmd_i, ccr_pkg::CCR_OP_REG_WRITE);
  assign cmd_legacy   = hits(cmd_i, ccr_pkg::CCR_OP_LEGACY_RESET) &&
                        q.live[ccr_pkg::CCR_BIT_LEGACY_RST];
  assign cmd_pair_rst = hits(cmd_i, ccr_pkg::CCR_OP_RESET) &&
                        q.armed;
  assign reload       = hw_reset_i || cmd_legacy || cmd_pair_rst;

  always_comb begin
    d              = q;
    d.rd_valid     = 1'b0;
    d.sw_reset     = 1'b0;
    d.erase_start  = 1'b0;
    d.erase_skip   = 1'b0;
    d.erase_reject = 1'b0;

    // Any command other than the reset enable disarms the pair.
    if (cmd_i.valid) begin
      d.armed = (cmd_i.op == ccr_pkg::CCR_OP_RESET_ENABLE);
    end

    if (cmd_read) begin
      d.rd_valid = 1'b1;
      if (cmd_i.addr == ccr_pkg::CCR_ADDR_BOOT) begin
        d.rd_data = q.boot;
      end else if (cmd_i.addr == ccr_pkg::CCR_ADDR_LIVE) begin
        d.rd_data = q.live;
      end else begin
        d.rd_data = ccr_pkg::CCR_UNMAPPED_VALUE;
      end
    end

    if (cmd_write) begin
      if (cmd_i.addr == ccr_pkg::CCR_ADDR_BOOT) begin
        // One-time bits only ever move away from the factory zero.
        d.boot = q.boot |
                 (cmd_i.wdata & ccr_pkg::CCR_BOOT_WR_MASK);
      end else if (cmd_i.addr == ccr_pkg::CCR_ADDR_LIVE) begin
        // The sector-map bit is outside the write mask.
        d.live = (q.live & ~ccr_pkg::CCR_LIVE_WR_MASK) |
                 (cmd_i.wdata & ccr_pkg::CCR_LIVE_WR_MASK);
      end
    end

    // Page buffer load address, folded at 256 when that wrap is chosen.
    if (q.live[ccr_pkg::CCR_BIT_PAGE_WRAP]) begin
      d.buf_addr = load_addr_i;
    end else begin
      d.buf_addr = load_addr_i & ccr_pkg::CCR_WRAP256_MASK;
    end

    unique case (q.fsm)
      ccr_pkg::CCR_IDLE: begin
        if (erase_req_i) begin
          if (erase_kind_i == ccr_pkg::CCR_ERASE_PARAM &&
              q.live[ccr_pkg::CCR_BIT_SMALL_SECT]) begin
            d.erase_reject = 1'b1;
          end else if (q.live[ccr_pkg::CCR_BIT_BLANK_CHECK]) begin
            d.fsm = ccr_pkg::CCR_STATUS;
          end else begin
            d.erase_start = 1'b1;
          end
        end
      end
      ccr_pkg::CCR_STATUS: begin
        if (sector_erase_ok_i) begin
          d.fsm      = ccr_pkg::CCR_BLANK;
          d.blank_rd = 1'b1;
        end else begin
          d.fsm         = ccr_pkg::CCR_IDLE;
          d.erase_start = 1'b1;
        end
      end
      ccr_pkg::CCR_BLANK: begin
        if (blank_word_valid_i) begin
          if (blank_word_i != ccr_pkg::CCR_BLANK_WORD) begin
            d.fsm         = ccr_pkg::CCR_IDLE;
            d.blank_rd    = 1'b0;
            d.erase_start = 1'b1;
          end else if (blank_last_i) begin
            d.fsm        = ccr_pkg::CCR_IDLE;
            d.blank_rd   = 1'b0;
            d.erase_skip = 1'b1;
          end
        end
      end
      default: begin
        d.fsm      = ccr_pkg::CCR_IDLE;
        d.blank_rd = 1'b0;
      end
    endcase

    // A reset reloads the live copy and abandons any erase in progress.
    if (reload) begin
      d.live         = boot_to_live(q.boot);
      d.sw_reset     = cmd_legacy || cmd_pair_rst;
      d.armed        = 1'b0;
      d.fsm          = ccr_pkg::CCR_IDLE;
      d.blank_rd     = 1'b0;
      d.erase_start  = 1'b0;
      d.erase_skip   = 1'b0;
      d.erase_reject = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= ccr_pkg::CCR_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign rd_data_o      = q.rd_data;
  assign rd_valid_o     = q.rd_valid;
  assign sw_reset_o     = q.sw_reset;
  assign blank_rd_o     = q.blank_rd;
  assign erase_start_o  = q.erase_start;
  assign erase_skip_o   = q.erase_skip;
  assign erase_reject_o = q.erase_reject;
  assign buf_addr_o     = q.buf_addr;
  assign cfg_o = '{
    blank_check_enable:   q.live[ccr_pkg::CCR_BIT_BLANK_CHECK],
    page_wrap_select:     q.live[ccr_pkg::CCR_BIT_PAGE_WRAP],
    small_sector_disable: q.live[ccr_pkg::CCR_BIT_SMALL_SECT],
    legacy_reset_enable:  q.live[ccr_pkg::CCR_BIT_LEGACY_RST]
  };

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_enable_cmd;
    cmd_i.valid && cmd_i.op == ccr_pkg::CCR_OP_RESET_ENABLE && !hw_reset_i;
  endsequence

  sequence s_reset_cmd;
    cmd_i.valid && cmd_i.op == ccr_pkg::CCR_OP_RESET && !hw_reset_i;
  endsequence

  sequence s_idle_erase_req;
    q.fsm == ccr_pkg::CCR_IDLE && erase_req_i && !reload &&
    erase_kind_i != ccr_pkg::CCR_ERASE_PARAM;
  endsequence

  sequence s_param_erase_req;
    q.fsm == ccr_pkg::CCR_IDLE && erase_req_i && !reload &&
    erase_kind_i == ccr_pkg::CCR_ERASE_PARAM;
  endsequence

  a_read_live_copy: assert property (
    cmd_read && cmd_i.addr == ccr_pkg::CCR_ADDR_LIVE |=>
      rd_valid_o && rd_data_o == $past(q.live))
    else $error("Live copy read returned wrong data.");

  a_reset_reload: assert property (
    hw_reset_i |=> q.live == ($past(q.boot) & ~ccr_pkg::CCR_RESERVED_MASK))
    else $error("Hardware reset did not reload the live copy.");

  a_boot_one_time: assert property (
    ($past(q.boot) & ~q.boot) == 8'h00)
    else $error("A boot bit returned to its factory state.");

  a_reserved_zero: assert property (
    ((q.boot | q.live) & ccr_pkg::CCR_RESERVED_MASK) == 8'h00)
    else $error("A reserved bit became set.");

  a_sector_map_locked: assert property (
    !reload |=> $stable(q.live[ccr_pkg::CCR_BIT_SMALL_SECT]))
    else $error("Live sector-map bit changed without a reset.");

  a_legacy_gate: assert property (
    cmd_i.valid && cmd_i.op == ccr_pkg::CCR_OP_LEGACY_RESET |=>
      sw_reset_o == $past(q.live[ccr_pkg::CCR_BIT_LEGACY_RST]))
    else $error("Legacy reset not gated by its enable bit.");

  a_pair_reset: assert property (
    s_enable_cmd ##1 s_reset_cmd |=> sw_reset_o && q.fsm == ccr_pkg::CCR_IDLE)
    else $error("Enable and reset pair did not reset.");

  a_no_check_start: assert property (
    s_idle_erase_req ##0 !cfg_o.blank_check_enable |=>
      erase_start_o ##1 !erase_start_o)
    else $error("Erase without blank check did not start at once.");

  a_status_fail_erase: assert property (
    s_idle_erase_req ##0 cfg_o.blank_check_enable ##1
      (!sector_erase_ok_i && !reload) |=> erase_start_o && !blank_rd_o)
    else $error("Failed previous erase did not force an erase.");

  a_blank_hit_erase: assert property (
    q.fsm == ccr_pkg::CCR_BLANK && blank_word_valid_i && !reload &&
      blank_word_i != ccr_pkg::CCR_BLANK_WORD |=> erase_start_o && !blank_rd_o)
    else $error("Programmed zero did not start the erase.");

  a_blank_skip: assert property (
    q.fsm == ccr_pkg::CCR_BLANK && blank_word_valid_i && blank_last_i &&
      !reload && blank_word_i == ccr_pkg::CCR_BLANK_WORD |=>
      erase_skip_o && !erase_start_o)
    else $error("Blank sector was not skipped.");

  a_wrap_256: assert property (
    !cfg_o.page_wrap_select |=> buf_addr_o == {1'b0, $past(load_addr_i[7:0])})
    else $error("Page buffer address not wrapped at 256.");

  a_wrap_512: assert property (
    cfg_o.page_wrap_select |=> buf_addr_o == $past(load_addr_i))
    else $error("Page buffer address wrapped at the 512 setting.");

  a_read_boot_copy: assert property (
    cmd_read && cmd_i.addr == ccr_pkg::CCR_ADDR_BOOT |=>
      rd_valid_o && rd_data_o == $past(q.boot))
    else $error("Boot copy read returned wrong data.");

  a_read_unmapped: assert property (
    cmd_read && cmd_i.addr != ccr_pkg::CCR_ADDR_BOOT &&
      cmd_i.addr != ccr_pkg::CCR_ADDR_LIVE |=>
      rd_valid_o && rd_data_o == ccr_pkg::CCR_UNMAPPED_VALUE)
    else $error("Unmapped read did not return the fill value.");

  a_live_write: assert property (
    cmd_write && cmd_i.addr == ccr_pkg::CCR_ADDR_LIVE && !reload |=>
      cfg_o.blank_check_enable ==
        $past(cmd_i.wdata[ccr_pkg::CCR_BIT_BLANK_CHECK]) &&
      cfg_o.page_wrap_select ==
        $past(cmd_i.wdata[ccr_pkg::CCR_BIT_PAGE_WRAP]) &&
      cfg_o.legacy_reset_enable ==
        $past(cmd_i.wdata[ccr_pkg::CCR_BIT_LEGACY_RST]))
    else $error("Live copy write did not take effect.");

  a_live_keeps_boot: assert property (
    cmd_write && cmd_i.addr == ccr_pkg::CCR_ADDR_LIVE |=> $stable(q.boot))
    else $error("Live copy write changed the boot copy.");

  a_check_enters_status: assert property (
    s_idle_erase_req ##0 cfg_o.blank_check_enable |=>
      q.fsm == ccr_pkg::CCR_STATUS && !erase_start_o)
    else $error("Blank check did not evaluate the erase status.");

  a_param_reject: assert property (
    s_param_erase_req ##0 cfg_o.small_sector_disable |=>
      erase_reject_o && !erase_start_o && q.fsm == ccr_pkg::CCR_IDLE)
    else $error("Parameter erase accepted with small sectors removed.");

  a_param_checked: assert property (
    s_param_erase_req ##0
      (!cfg_o.small_sector_disable && cfg_o.blank_check_enable) |=>
      q.fsm == ccr_pkg::CCR_STATUS && !erase_reject_o)
    else $error("Parameter erase skipped the blank check.");

  a_param_no_check: assert property (
    s_param_erase_req ##0
      (!cfg_o.small_sector_disable && !cfg_o.blank_check_enable) |=>
      erase_start_o && !erase_reject_o)
    else $error("Parameter erase did not start at once.");

  a_blank_read_start: assert property (
    q.fsm == ccr_pkg::CCR_STATUS && sector_erase_ok_i && !reload |=>
      blank_rd_o && q.fsm == ccr_pkg::CCR_BLANK && !erase_start_o)
    else $error("Good previous erase did not start the blank read.");

  a_blank_wait: assert property (
    q.fsm == ccr_pkg::CCR_BLANK && !reload &&
      (!blank_word_valid_i || (!blank_last_i &&
        blank_word_i == ccr_pkg::CCR_BLANK_WORD)) |=>
      blank_rd_o && !erase_start_o && !erase_skip_o)
    else $error("Blank read ended before a decision.");

  a_blank_rd_level: assert property (
    blank_rd_o == (q.fsm == ccr_pkg::CCR_BLANK))
    else $error("Blank read request out of step with its state.");

  a_one_outcome: assert property (
    $onehot0({erase_start_o, erase_skip_o, erase_reject_o}))
    else $error("More than one erase outcome at once.");

  a_reload_aborts: assert property (
    reload |=> q.fsm == ccr_pkg::CCR_IDLE && !blank_rd_o &&
      !erase_start_o && !erase_skip_o && !erase_reject_o)
    else $error("A reset did not abandon the erase in progress.");

  a_sw_reload: assert property (
    sw_reset_o |-> q.live == (q.boot & ~ccr_pkg::CCR_RESERVED_MASK))
    else $error("Software reset did not reload the live copy.");

  a_sw_reset_cause: assert property (
    sw_reset_o |-> $past(cmd_i.valid) &&
      ($past(cmd_i.op) == ccr_pkg::CCR_OP_LEGACY_RESET ||
       $past(cmd_i.op) == ccr_pkg::CCR_OP_RESET))
    else $error("Software reset without a reset command.");

endmodule // ccr_command_config

/* verilog/ccr_pkg.sv */
// Constants, carriers and state types of the command behaviour config block.
package ccr_pkg;

  localparam logic [7:0]  CCR_OP_REG_READ     = 8'h65;
  localparam logic [7:0]  CCR_OP_REG_WRITE    = 8'h71;
  localparam logic [7:0]  CCR_OP_LEGACY_RESET = 8'hF0;
  localparam logic [7:0]  CCR_OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0]  CCR_OP_RESET        = 8'h99;

  // Register addresses seen by the generic register commands.
  localparam logic [31:0] CCR_ADDR_BOOT       = 32'h0000_0004;
  localparam logic [31:0] CCR_ADDR_LIVE       = 32'h0080_0004;

  localparam int          CCR_BIT_BLANK_CHECK = 5;
  localparam int          CCR_BIT_PAGE_WRAP   = 4;
  localparam int          CCR_BIT_SMALL_SECT  = 3;
  localparam int          CCR_BIT_LEGACY_RST  = 0;

  localparam logic [7:0]  CCR_BOOT_WR_MASK    = 8'h39;
  localparam logic [7:0]  CCR_LIVE_WR_MASK    = 8'h31;
  localparam logic [7:0]  CCR_RESERVED_MASK   = 8'hC6;
  localparam logic [7:0]  CCR_FACTORY_VALUE   = 8'h00;
  localparam logic [7:0]  CCR_UNMAPPED_VALUE  = 8'h00;

  localparam logic [1:0]  CCR_ERASE_PARAM     = 2'h0;
  localparam logic [1:0]  CCR_ERASE_SECTOR    = 2'h1;
  localparam logic [1:0]  CCR_ERASE_BULK      = 2'h2;

  localparam logic [31:0] CCR_BLANK_WORD      = 32'hFFFF_FFFF;
  localparam logic [8:0]  CCR_WRAP256_MASK    = 9'h0FF;
  localparam logic [8:0]  CCR_ADDR_RESET      = 9'h000;

  typedef struct packed {
    logic        valid;
    logic [7:0]  op;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } ccr_cmd_t;

  typedef struct packed {
    logic blank_check_enable;
    logic page_wrap_select;
    logic small_sector_disable;
    logic legacy_reset_enable;
  } ccr_cfg_t;

  typedef enum logic [2:0] {
    CCR_IDLE   = 3'b001,
    CCR_STATUS = 3'b010,
    CCR_BLANK  = 3'b100
  } ccr_fsm_t;

  typedef struct packed {
    logic [7:0] boot;
    logic [7:0] live;
    logic       armed;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       sw_reset;
    ccr_fsm_t   fsm;
    logic       erase_start;
    logic       erase_skip;
    logic       erase_reject;
    logic       blank_rd;
    logic [8:0] buf_addr;
  } ccr_state_t;

  localparam ccr_state_t CCR_STATE_RESET = '{
    boot:         CCR_FACTORY_VALUE,
    live:         CCR_FACTORY_VALUE,
    armed:        1'b0,
    rd_data:      CCR_UNMAPPED_VALUE,
    rd_valid:     1'b0,
    sw_reset:     1'b0,
    fsm:          CCR_IDLE,
    erase_start:  1'b0,
    erase_skip:   1'b0,
    erase_reject: 1'b0,
    blank_rd:     1'b0,
    buf_addr:     CCR_ADDR_RESET
  };

endpackage

/* testbench/ccr_erase_model.sv */
// Erase engine model that streams sector words during a blank check.
`timescale 1ns/1ns
module ccr_erase_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        blank_rd_i,
  input  wire logic [7:0]  dirty_idx_i,
  input  wire logic [7:0]  n_words_i,
  output logic             word_valid_o,
  output logic [31:0]      word_o,
  output logic             last_o
);
  logic [7:0] idx_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_q        <= 8'h00;
      word_valid_o <= 1'b0;
      word_o       <= 32'h0000_0000;
      last_o       <= 1'b0;
    end else if (blank_rd_i && idx_q < n_words_i) begin
      word_valid_o <= 1'b1;
      word_o       <= (idx_q == dirty_idx_i) ? 32'hFFFF_7FFF : 32'hFFFF_FFFF;
      last_o       <= (idx_q == n_words_i - 8'h01);
      idx_q        <= idx_q + 8'h01;
    end else begin
      // Outside a word the bus inverts its previous value every cycle.
      word_valid_o <= 1'b0;
      last_o       <= 1'b0;
      word_o       <= ~word_o;
      if (!blank_rd_i) begin
        idx_q <= 8'h00;
      end
    end
  end
endmodule // ccr_erase_model

/* testbench/tb_ccr_command_config.sv */
// Self-checking bench of the command behaviour config block.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_ccr_command_config;
  logic sys_clk_i = 0, rstn_i = 0, hw_reset_i = 0, erase_req_i = 0;
  logic sector_erase_ok_i = 0, blank_rd_o, word_v, last_w;
  logic erase_start_o, erase_skip_o, erase_reject_o, rd_valid_o, sw_reset_o;
  logic [1:0] erase_kind_i = 0;
  logic [7:0] rd_data_o, dirty_q = 8'hFF, v, w, boot_m, live_m;
  logic [8:0] load_addr_i = 0, buf_addr_o, la;
  logic [31:0] word_w;
  logic [2:0] res;
  ccr_pkg::ccr_cmd_t cmd_i = '0;
  ccr_pkg::ccr_cfg_t cfg_o;
  int failures = 0, n_checks = 0, cyc = 0, seed = 12085;
  always #2 sys_clk_i = ~sys_clk_i;
  ccr_command_config ccr_command_config_i (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .hw_reset_i(hw_reset_i), .cmd_i(cmd_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .sw_reset_o(sw_reset_o),
    .cfg_o(cfg_o), .erase_req_i(erase_req_i), .erase_kind_i(erase_kind_i),
    .sector_erase_ok_i(sector_erase_ok_i), .blank_rd_o(blank_rd_o),
    .blank_word_valid_i(word_v), .blank_word_i(word_w),
    .blank_last_i(last_w), .erase_start_o(erase_start_o),
    .erase_skip_o(erase_skip_o), .erase_reject_o(erase_reject_o),
    .load_addr_i(load_addr_i), .buf_addr_o(buf_addr_o));
  ccr_erase_model ccr_erase_model_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .blank_rd_i(blank_rd_o), .dirty_idx_i(dirty_q), .n_words_i(8'h08),
    .word_valid_o(word_v), .word_o(word_w), .last_o(last_w));
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic cmd(input logic [7:0] op, input logic [31:0] a,
                     input logic [7:0] d);
    @(posedge sys_clk_i) cmd_i <= {1'b1, op, a, d};
    @(posedge sys_clk_i) cmd_i.valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    cmd(ccr_pkg::CCR_OP_REG_READ, a, 8'h00);
    `CHK(rd_valid_o, 1'b1)
    v = rd_data_o;
  endtask
  task automatic wr_live(input logic [7:0] d);
    cmd(ccr_pkg::CCR_OP_REG_WRITE, ccr_pkg::CCR_ADDR_LIVE, d);
    live_m = (d & 8'h31) | (boot_m & 8'h08);
  endtask
  task automatic erase(input logic [1:0] k, input logic ok,
                       input logic [7:0] dirty);
    @(posedge sys_clk_i) erase_req_i <= 1'b1;
    erase_kind_i <= k;
    sector_erase_ok_i <= ok;
    dirty_q <= dirty;
    @(posedge sys_clk_i) erase_req_i <= 1'b0;
    res = 3'b000;
    for (int n = 0; n < 40 && res == 3'b000; n++) begin
      #1 res = {erase_start_o, erase_skip_o, erase_reject_o};
      if (res == 3'b000) @(posedge sys_clk_i);
    end
  endtask
  function automatic logic [2:0] exp_erase(logic [7:0] lv, logic [1:0] k,
                                           logic ok, logic [7:0] dirty);
    if (k == ccr_pkg::CCR_ERASE_PARAM && lv[3]) return 3'b001;
    if (!lv[5] || !ok || dirty != 8'hFF) return 3'b100;
    return 3'b010;
  endfunction
  task automatic por();
    @(posedge sys_clk_i) rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    boot_m = 8'h00;
    live_m = 8'h00;
  endtask
  initial begin
    por();
    rd(ccr_pkg::CCR_ADDR_BOOT);
    `CHK(v, 8'h00)
    rd(ccr_pkg::CCR_ADDR_LIVE);
    `CHK(v, 8'h00)
    rd(32'h0000_0100);
    `CHK(v, 8'h00)
    $display("test reset_values done");
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 8'hFF : $random(seed);
      la = $random(seed);
      wr_live(w);
      `CHK(cfg_o, {live_m[5], live_m[4], live_m[3], live_m[0]})
      rd(ccr_pkg::CCR_ADDR_LIVE);
      `CHK(v, live_m)
      rd(ccr_pkg::CCR_ADDR_BOOT);
      `CHK(v, boot_m)
      @(posedge sys_clk_i) load_addr_i <= la;
      @(posedge sys_clk_i) #1;
      `CHK(buf_addr_o, live_m[4] ? la : la & 9'h0FF)
    end
    $display("test live_copy done");
    for (int b = 0; b < 2; b++) begin
      wr_live(b ? 8'h20 : 8'h00);
      for (int k = 0; k < 3; k++) begin
        for (int c = 0; c < 3; c++) begin
          w = (c == 1) ? ($random(seed) & 8'h07) : 8'hFF;
          erase(k, c != 0, w);
          `CHK(res, exp_erase(live_m, k, c != 0, w))
          `CHK(blank_rd_o, 1'b0)
        end
      end
    end
    $display("test blank_check done");
    wr_live(8'h01);
    cmd(ccr_pkg::CCR_OP_LEGACY_RESET, 32'h0, 8'h00);
    `CHK(sw_reset_o, 1'b1)
    rd(ccr_pkg::CCR_ADDR_LIVE);
    `CHK(v, boot_m)
    cmd(ccr_pkg::CCR_OP_LEGACY_RESET, 32'h0, 8'h00);
    `CHK(sw_reset_o, 1'b0)
    cmd(ccr_pkg::CCR_OP_RESET_ENABLE, 32'h0, 8'h00);
    cmd(ccr_pkg::CCR_OP_RESET, 32'h0, 8'h00);
    `CHK(sw_reset_o, 1'b1)
    cmd(ccr_pkg::CCR_OP_RESET_ENABLE, 32'h0, 8'h00);
    rd(ccr_pkg::CCR_ADDR_LIVE);
    cmd(ccr_pkg::CCR_OP_RESET, 32'h0, 8'h00);
    `CHK(sw_reset_o, 1'b0)
    $display("test soft_reset done");
    // A fresh part takes its sector map before any array operation.
    por();
    cmd(ccr_pkg::CCR_OP_REG_WRITE, ccr_pkg::CCR_ADDR_BOOT, 8'hFF);
    rd(ccr_pkg::CCR_ADDR_BOOT);
    `CHK(v, 8'h39)
    cmd(ccr_pkg::CCR_OP_REG_WRITE, ccr_pkg::CCR_ADDR_BOOT, 8'h00);
    rd(ccr_pkg::CCR_ADDR_BOOT);
    `CHK(v, 8'h39)
    boot_m = 8'h39;
    @(posedge sys_clk_i) hw_reset_i <= 1'b1;
    @(posedge sys_clk_i) hw_reset_i <= 1'b0;
    rd(ccr_pkg::CCR_ADDR_LIVE);
    `CHK(v, 8'h39)
    rd(32'h0000_0100);
    `CHK(v, 8'h00)
    wr_live(8'h00);
    rd(ccr_pkg::CCR_ADDR_LIVE);
    `CHK(v, 8'h08)
    erase(ccr_pkg::CCR_ERASE_PARAM, 1'b1, 8'hFF);
    `CHK(res, 3'b001)
    $display("test boot_copy done");
    end_of_test();
  end
endmodule // tb_ccr_command_config
